// [rtl/fmo_file_minus_one_op_path.sv]
// Execution path of the file-register decrement instruction.
// Assumes data memory returns read data combinationally within the read phase.
`timescale 1ns/1ps
module fmo_file_minus_one_op_path
  import fmo_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_pointer,
  input wire logic [11:0] index_ptr,
  input wire logic [7:0] mem_rdata,
  output logic [11:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [7:0] acc_r,
  output logic [4:0] status_r,
  output logic busy
);
  fmo_phase_e phase_r;
  logic [7:0] file_addr_r;
  logic dest_r;
  logic bank_r;
  logic [7:0] opnd_r;
  logic [7:0] result_r;
  logic lit_ofs_mode;
  logic [11:0] addr_w;
  logic is_file_minus_one_op;
  logic [2:0] busy_run_r;

  function automatic logic [4:0] fmo_dec_flags(input logic [7:0] v);
    logic [7:0] r;
    r = v - 8'h01;
    fmo_dec_flags = '0;
    fmo_dec_flags[FMO_FLAG_C] = (v != 8'h00);
    fmo_dec_flags[FMO_FLAG_DC] = (v[3:0] != 4'h0);
    fmo_dec_flags[FMO_FLAG_Z] = (r == 8'h00);
    fmo_dec_flags[FMO_FLAG_OV] = (v == 8'h80);
    fmo_dec_flags[FMO_FLAG_N] = r[7];
  endfunction

  assign is_file_minus_one_op = instr_valid && (instr_word[15:10] == FMO_OPCODE);
  assign busy = (phase_r != FMO_Q1_DECODE);

  fmo_addr_gen u_addr (
    .file_addr(file_addr_r),
    .bank_sel(bank_r),
    .ext_set_en(ext_set_en),
    .bank_pointer(bank_pointer),
    .index_ptr(index_ptr),
    .data_addr(addr_w),
    .lit_ofs_mode(lit_ofs_mode)
  );
  assign mem_addr = addr_w;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= FMO_Q1_DECODE;
    end else begin
      unique case (phase_r)
        FMO_Q1_DECODE: phase_r <= is_file_minus_one_op ? FMO_Q2_READ : FMO_Q1_DECODE;
        FMO_Q2_READ: phase_r <= FMO_Q3_PROCESS;
        FMO_Q3_PROCESS: phase_r <= FMO_Q4_WRITE;
        FMO_Q4_WRITE: phase_r <= FMO_Q1_DECODE;
      endcase
    end
  end

  // Operand fields are latched so later instruction words cannot disturb the access.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      file_addr_r <= FMO_RESET_BYTE;
      dest_r <= 1'b1;
      bank_r <= 1'b0;
    end else if (phase_r == FMO_Q1_DECODE && is_file_minus_one_op) begin
      file_addr_r <= instr_word[7:0];
      bank_r <= instr_word[8];
      dest_r <= instr_word[9];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opnd_r <= FMO_RESET_BYTE;
      result_r <= FMO_RESET_BYTE;
    end else if (phase_r == FMO_Q2_READ) begin
      opnd_r <= mem_rdata;
    end else if (phase_r == FMO_Q3_PROCESS) begin
      result_r <= opnd_r - 8'h01;
    end
  end

  // Writes happen only in the write phase, so a read-back of the same address sees the old value.
  assign mem_we = (phase_r == FMO_Q4_WRITE) && dest_r;
  assign mem_wdata = result_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= FMO_RESET_BYTE;
    end else if (phase_r == FMO_Q4_WRITE && !dest_r) begin
      acc_r <= result_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= 5'h00;
    end else if (phase_r == FMO_Q4_WRITE) begin
      status_r <= fmo_dec_flags(opnd_r);
    end
  end

  // A stuck phase machine would hold busy forever; a short count catches it without a long repetition.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_run_r <= 3'h0;
    end else if (!busy) begin
      busy_run_r <= 3'h0;
    end else if (busy_run_r != 3'h7) begin
      busy_run_r <= busy_run_r + 3'h1;
    end
  end

  a_acc_dest_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE && !dest_r) |=> (acc_r == $past(opnd_r) - 8'h01) && !$past(mem_we))
    else $error("Accumulator not loaded with decremented value.");
  a_file_write_back: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE && dest_r) |-> mem_we && (mem_wdata == opnd_r - 8'h01))
    else $error("File write-back missing or wrong.");
  a_acc_hold_dest: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE && dest_r) |=> $stable(acc_r))
    else $error("Accumulator changed on file destination.");
  a_fields_latched: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q1_DECODE && is_file_minus_one_op) |=> (file_addr_r == $past(instr_word[7:0])) && (dest_r == $past(instr_word[9])))
    else $error("Operand fields not latched.");
  a_lit_ofs_sel: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && !bank_r && ext_set_en && file_addr_r <= 8'h5f) |-> mem_addr == index_ptr + {4'h0, file_addr_r})
    else $error("Indexed literal-offset address wrong.");
  a_bank_direct: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && bank_r) |-> mem_addr == {bank_pointer, file_addr_r} && !lit_ofs_mode)
    else $error("Banked address wrong.");
  a_zero_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE) |=> status_r[FMO_FLAG_Z] == ($past(opnd_r) == 8'h01) && status_r[FMO_FLAG_C] == ($past(opnd_r) != 8'h00))
    else $error("Zero or carry flag wrong.");
  a_four_phases: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q1_DECODE && is_file_minus_one_op) |-> ##3 phase_r == FMO_Q4_WRITE ##1 phase_r == FMO_Q1_DECODE)
    else $error("Instruction did not take four phases.");

  a_half_borrow: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE)
    |=> (status_r[FMO_FLAG_DC] == ($past(opnd_r[3:0]) != 4'h0)))
    else $error("Half borrow flag wrong.");

  a_range_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE)
    |=> (status_r[FMO_FLAG_OV] == ($past(opnd_r) == 8'h80)))
    else $error("Range flag wrong.");

  a_negative_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q4_WRITE)
    |=> (status_r[FMO_FLAG_N] == (($past(opnd_r) == 8'h00) || ($past(opnd_r) > 8'h80))))
    else $error("Negative flag wrong.");

  a_status_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r != FMO_Q4_WRITE)
    |=> $stable(status_r))
    else $error("Status changed outside the write phase.");

  a_acc_hold_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r != FMO_Q4_WRITE)
    |=> $stable(acc_r))
    else $error("Accumulator changed outside the write phase.");

  a_no_file_write: assert property (@(posedge clk) disable iff (!arst_n)
    !dest_r
    |-> !mem_we)
    else $error("File written on accumulator destination.");

  a_we_write_phase: assert property (@(posedge clk) disable iff (!arst_n)
    mem_we
    |-> (phase_r == FMO_Q4_WRITE) && dest_r)
    else $error("Write strobe outside the write phase.");

  a_opnd_capture: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q2_READ)
    |=> (opnd_r == $past(mem_rdata)))
    else $error("Operand not taken in the read phase.");

  a_result_calc: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q3_PROCESS)
    |=> (result_r == $past(opnd_r) - 8'h01))
    else $error("Result not one below the operand.");

  a_access_low: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && !bank_r && (!ext_set_en || file_addr_r > FMO_LIT_OFS_MAX) && file_addr_r < FMO_ACCESS_SPLIT)
    |-> (mem_addr[11:8] == 4'h0) && (mem_addr[7:0] == file_addr_r))
    else $error("Low access bank address wrong.");

  a_access_high: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && !bank_r && file_addr_r >= FMO_ACCESS_SPLIT)
    |-> (mem_addr == {FMO_ACCESS_HI_BANK, file_addr_r}))
    else $error("High access bank address wrong.");

  a_lit_ofs_only: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && lit_ofs_mode)
    |-> !bank_r && ext_set_en && (file_addr_r <= FMO_LIT_OFS_MAX))
    else $error("Indexed mode outside its address range.");

  a_busy_refused: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && instr_valid)
    |=> $stable(file_addr_r) && $stable(dest_r) && $stable(bank_r))
    else $error("Operand fields changed while busy.");

  a_idle_ignore: assert property (@(posedge clk) disable iff (!arst_n)
    (phase_r == FMO_Q1_DECODE && !is_file_minus_one_op)
    |=> (phase_r == FMO_Q1_DECODE))
    else $error("Idle path left without a decrement word.");

  a_busy_bounded: assert property (@(posedge clk) disable iff (!arst_n)
    busy
    |-> (int'(busy_run_r) < FMO_Q_PHASES - 1))
    else $error("Busy held longer than one instruction.");
endmodule // fmo_file_minus_one_op_path

// [pkg/fmo_pkg.sv]
// Constants for the file-register decrement datapath.
// Assumes a core that issues one decoded instruction per instruction cycle.
package fmo_pkg;
  localparam logic [5:0] FMO_OPCODE = 6'h01;
  localparam logic [7:0] FMO_LIT_OFS_MAX = 8'h5f;
  localparam logic [7:0] FMO_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] FMO_ACCESS_HI_BANK = 4'hf;
  localparam logic [7:0] FMO_RESET_BYTE = 8'h00;
  localparam int FMO_ADDR_W = 12;
  localparam int FMO_Q_PHASES = 4;
  localparam int FMO_FLAG_C = 0;
  localparam int FMO_FLAG_DC = 1;
  localparam int FMO_FLAG_Z = 2;
  localparam int FMO_FLAG_OV = 3;
  localparam int FMO_FLAG_N = 4;
  typedef enum logic [1:0] {
    FMO_Q1_DECODE = 2'b00,
    FMO_Q2_READ = 2'b01,
    FMO_Q3_PROCESS = 2'b11,
    FMO_Q4_WRITE = 2'b10
  } fmo_phase_e;
endpackage

// [rtl/fmo_addr_gen.sv]
// Data-memory address former for byte-oriented file instructions.
// Assumes bank pointer and index pointer are stable during the instruction.
`timescale 1ns/1ps
module fmo_addr_gen
  import fmo_pkg::*;
(
  input wire logic [7:0] file_addr,
  input wire logic bank_sel,
  input wire logic ext_set_en,
  input wire logic [3:0] bank_pointer,
  input wire logic [11:0] index_ptr,
  output logic [11:0] data_addr,
  output logic lit_ofs_mode
);
  always_comb begin
    lit_ofs_mode = !bank_sel && ext_set_en && (file_addr <= FMO_LIT_OFS_MAX);
    if (lit_ofs_mode) begin
      data_addr = index_ptr + {4'h0, file_addr};
    end else if (bank_sel) begin
      data_addr = {bank_pointer, file_addr};
    end else if (file_addr < FMO_ACCESS_SPLIT) begin
      data_addr = {4'h0, file_addr};
    end else begin
      data_addr = {FMO_ACCESS_HI_BANK, file_addr};
    end
  end
endmodule // fmo_addr_gen

// [dv/tb_top.sv]
// Self-checking bench for the file-register decrement path.
// Assumes the memory answers at once, so the operand is driven on mem_rdata.
`timescale 1ns/1ps
module tb_top
  import fmo_pkg::*;
;
  typedef struct {logic [11:0] a; logic [7:0] r; logic d; logic [4:0] s; logic [7:0] acc;} fmo_exp_s;
  logic clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, ext_set_en = 1'b0, mem_we, busy, bsy_q = 1'b0, wr_seen = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_pointer = 4'h0;
  logic [11:0] index_ptr = 12'h000, mem_addr;
  logic [7:0] mem_rdata = 8'h00, mem_wdata, acc_r, acc_x = 8'h00;
  logic [4:0] status_r;
  logic [31:0] lfsr = 32'h50a64a79;
  logic [7:0] ops [8] = '{8'h00, 8'h80, 8'h10, 8'h01, 8'hff, 8'h7f, 8'h0f, 8'h02};
  logic [7:0] fa [8] = '{8'h5f, 8'h60, 8'h00, 8'hff, 8'h5f, 8'h60, 8'h00, 8'hff};
  int fails = 0, tests_run = 0, cyc = 0;
  fmo_exp_s q[$];
  fmo_exp_s e;
  always #10 clk = ~clk;
  fmo_file_minus_one_op_path i_dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .ext_set_en(ext_set_en), .bank_pointer(bank_pointer), .index_ptr(index_ptr), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc_r(acc_r), .status_r(status_r),
    .busy(busy));
  function automatic logic [31:0] nxt(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string n, logic [11:0] x, logic [11:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // The expectation is noted before the request goes out, so the monitor never waits on it.
  task automatic issue(logic [7:0] f, logic d, logic a, logic x, logic [7:0] v);
    fmo_exp_s n;
    @(posedge clk);
    lfsr = nxt(lfsr);
    if (a) n.a = {lfsr[3:0], f};
    else if (x && f <= FMO_LIT_OFS_MAX) n.a = lfsr[27:16] + {4'h0, f};
    else n.a = {(f < FMO_ACCESS_SPLIT) ? 4'h0 : FMO_ACCESS_HI_BANK, f};
    n.r = v - 8'h01;
    n.d = d;
    n.s = {n.r[7], v == 8'h80, n.r == 8'h00, v[3:0] != 4'h0, v != 8'h00};
    if (!d) acc_x = n.r;
    n.acc = acc_x;
    q.push_back(n);
    bank_pointer <= lfsr[3:0];
    index_ptr <= lfsr[27:16];
    ext_set_en <= x;
    mem_rdata <= v;
    instr_word <= {FMO_OPCODE, d, a, f};
    instr_valid <= 1'b1;
    @(posedge clk);
    // A word offered while busy must leave the running access untouched; the one with another opcode comes once idle and must start nothing.
    instr_word <= {FMO_OPCODE, ~d, a, ~f};
    repeat (3) @(posedge clk);
    instr_word <= {~FMO_OPCODE, d, a, f};
    @(posedge clk);
    instr_valid <= 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      give_verdict();
    end else begin
      bsy_q <= busy;
      if (busy && !bsy_q) chk("mem_addr", q[0].a, mem_addr);
      if (mem_we) begin
        wr_seen <= 1'b1;
        chk("mem_wdata", {q[0].d, 3'h0, q[0].r}, {1'b1, 3'h0, mem_wdata});
      end
      if (!busy && bsy_q) begin
        e = q.pop_front();
        wr_seen <= 1'b0;
        chk("acc_r", {4'h0, e.acc}, {4'h0, acc_r});
        chk("status_r", {7'h00, e.s}, {7'h00, status_r});
        chk("mem_we", {11'h000, e.d}, {11'h000, wr_seen});
        $display("test done, acc %h status %h", acc_r, status_r);
      end
    end
  end
  // Boundary operands and addresses first, then random traffic in every mode.
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      if (i < 8) issue(fa[i], lfsr[8], 1'b0, i < 4, ops[i]);
      else issue(lfsr[7:0], lfsr[8], lfsr[9], lfsr[10], lfsr[23:16]);
    end
    repeat (2) @(posedge clk);
    chk("pending", 12'h000, 12'(q.size()));
    give_verdict();
  end
endmodule // tb_top
